/* File: logic/rbp_pkg.sv */
// Purpose: Constants for the row pulse and serial pin block
// Assumes: core_clk at 100 MHz
// Notes: Times held in their own units; counts derived here
`default_nettype none
package rbp_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int BASE_RATE_HZ = 8000;
    // Normal row timing at the base rate, in microseconds
    localparam int ROW_HIGH_US = 175_000;
    localparam int ROW_LOW_US = 25_000;
    // Cue scan timing at the base rate, in nanoseconds
    localparam int CUE_HIGH_NS = 109_370;
    localparam int CUE_LOW_NS = 15_630;
    localparam int ROW_HIGH_CYC = ROW_HIGH_US * (CLK_HZ / 1_000_000);
    localparam int ROW_LOW_CYC = ROW_LOW_US * (CLK_HZ / 1_000_000);
    localparam int CUE_HIGH_CYC = (CUE_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CUE_LOW_CYC = (CUE_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CNT_W = 32;
endpackage : rbp_pkg
`default_nettype wire

/* File: logic/rbp_row_pulse.sv */
// Purpose: Row boundary pulse timer and serial pin drivers
// Assumes: sclk is the master's serial clock; ss_n is active low
// Notes: Row pulse pin is open drain; interval counts scale by rate_div
`default_nettype none
module rbp_row_pulse #(
    parameter int ROW_HIGH_CYC = rbp_pkg::ROW_HIGH_CYC,
    parameter int ROW_LOW_CYC = rbp_pkg::ROW_LOW_CYC,
    parameter int CUE_HIGH_CYC = rbp_pkg::CUE_HIGH_CYC,
    parameter int CUE_LOW_CYC = rbp_pkg::CUE_LOW_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic active,
    input wire logic recording,
    input wire logic cue_mode,
    input wire logic [3:0] rate_div,
    output logic row_boundary_pulse_o,
    output logic row_boundary_pulse_oe,
    output logic row_end,
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso_bit,
    output logic miso_o,
    output logic miso_oe,
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    typedef enum logic [1:0] {ST_IDLE, ST_PRELOAD, ST_HIGH, ST_LOW} rbp_state_t;
    rbp_state_t state_ff;
    logic [31:0] cnt_ff;
    logic rec_seen_ff;
    logic [31:0] hi_len, lo_len;

    // Scaled lengths; rate_div of 1 is the base rate, larger is slower
    function automatic logic [31:0] scale(input int cyc, input logic [3:0] d);
        logic [35:0] p;
        p = 36'(cyc) * 36'(d == 4'h0 ? 4'h1 : d);
        return p[31:0];
    endfunction : scale

    always_comb
    begin
        hi_len = scale(cue_mode ? CUE_HIGH_CYC : ROW_HIGH_CYC, rate_div);
        lo_len = scale(cue_mode ? CUE_LOW_CYC : ROW_LOW_CYC, rate_div);
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= 32'h0;
        end
        else if (!active)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= 32'h0;
        end
        else
        begin
            cnt_ff <= cnt_ff + 32'h1;
            unique case (state_ff)
                ST_IDLE:
                begin
                    cnt_ff <= 32'h0;
                    state_ff <= (recording && !rec_seen_ff) ? ST_PRELOAD : ST_HIGH;
                end
                ST_PRELOAD:
                    if (cnt_ff >= lo_len - 32'h1)
                    begin
                        cnt_ff <= 32'h0;
                        state_ff <= ST_HIGH;
                    end
                ST_HIGH:
                    if (cnt_ff >= hi_len - 32'h1)
                    begin
                        cnt_ff <= 32'h0;
                        state_ff <= ST_LOW;
                    end
                ST_LOW:
                    if (cnt_ff >= lo_len - 32'h1)
                    begin
                        cnt_ff <= 32'h0;
                        state_ff <= ST_HIGH;
                    end
            endcase
        end
    end

    // Preload only once per activation, and only if recording as the timer starts
    always_ff @(posedge core_clk)
    begin
        if (reset)
            rec_seen_ff <= 1'b0;
        else if (!active)
            rec_seen_ff <= 1'b0;
        else if (state_ff == ST_PRELOAD)
            rec_seen_ff <= 1'b1;
    end

    logic low_ff;
    always_ff @(posedge core_clk)
    begin
        if (reset)
            low_ff <= 1'b0;
        else
            low_ff <= (state_ff == ST_LOW);
    end
    assign row_boundary_pulse_o = 1'b0;
    assign row_boundary_pulse_oe = low_ff;
    assign row_end = low_ff;

    // Length of the current low run, for the interval check
    logic [31:0] low_run_ff;
    always_ff @(posedge core_clk)
    begin
        if (reset || !low_ff)
            low_run_ff <= 32'h0;
        else
            low_run_ff <= low_run_ff + 32'h1;
    end

    // Select synchronised into core domain for the output enable
    logic ss_s1_ff, ss_s2_ff;
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ss_s1_ff <= 1'b1;
            ss_s2_ff <= 1'b1;
        end
        else
        begin
            ss_s1_ff <= ss_n;
            ss_s2_ff <= ss_s1_ff;
        end
    end

    // Link side: shift on rising sclk while selected
    logic [7:0] sh_ff;
    logic [2:0] bit_ff;
    logic tog_ff;
    logic [7:0] hold_ff;
    // Core reset also clears the bit count, so a count never starts unknown
    always_ff @(posedge sclk or posedge ss_n or posedge reset)
    begin
        if (ss_n || reset)
            bit_ff <= 3'h0;
        else
            bit_ff <= bit_ff + 3'h1;
    end
    always_ff @(posedge sclk)
    begin
        if (!ss_n)
            sh_ff <= {sh_ff[6:0], mosi};
    end
    // Toggle must match the core side after reset; serial clock may be stopped
    always_ff @(posedge sclk or posedge reset)
    begin
        if (reset)
        begin
            tog_ff <= 1'b0;
            hold_ff <= 8'h00;
        end
        else if (!ss_n && bit_ff == 3'h7)
        begin
            hold_ff <= {sh_ff[6:0], mosi};
            tog_ff <= ~tog_ff;
        end
    end

    // Toggle crossing into core domain
    logic t1_ff, t2_ff, t3_ff;
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            t1_ff <= 1'b0;
            t2_ff <= 1'b0;
            t3_ff <= 1'b0;
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
        end
        else
        begin
            t1_ff <= tog_ff;
            t2_ff <= t1_ff;
            t3_ff <= t2_ff;
            rx_valid <= t2_ff ^ t3_ff;
            if (t2_ff ^ t3_ff)
                rx_byte <= hold_ff;
        end
    end

    logic miso_ff;
    always_ff @(negedge sclk or posedge ss_n)
    begin
        if (ss_n)
            miso_ff <= 1'b0;
        else
            miso_ff <= miso_bit;
    end
    assign miso_o = miso_ff;
    assign miso_oe = !ss_n && !ss_s2_ff;

    chk_pulse_low_len: assert property (@(posedge core_clk) disable iff (reset)
        $rose(state_ff == ST_LOW) && active |-> (state_ff == ST_LOW)[*2]
    ) else $error("row pulse low too short");
    chk_miso_release: assert property (@(posedge core_clk) disable iff (reset)
        ss_n |-> !miso_oe
    ) else $error("serial output driven while deselected");
    sequence s_low_done;
        low_ff && state_ff == ST_HIGH;
    endsequence
    chk_low_run_len: assert property (@(posedge core_clk) disable iff (reset)
        s_low_done |-> low_run_ff == lo_len - 32'h1
    ) else $error("row pulse low interval wrong length");
    chk_rx_one_cycle: assert property (@(posedge core_clk) disable iff (reset)
        rx_valid |=> !rx_valid
    ) else $error("receive strobe held too long");
    chk_open_drain: assert property (@(posedge core_clk) disable iff (reset)
        row_boundary_pulse_oe |-> !row_boundary_pulse_o
    ) else $error("row pulse driven high");
    chk_preload_first: assert property (@(posedge core_clk) disable iff (reset)
        state_ff == ST_PRELOAD |=> state_ff != ST_LOW
    ) else $error("preload went straight low");
    chk_high_to_low: assert property (@(posedge core_clk) disable iff (reset)
        $past(state_ff) == ST_HIGH && state_ff == ST_LOW |-> cnt_ff == 32'h0
    ) else $error("low interval did not restart count");
    chk_idle_inactive: assert property (@(posedge core_clk) disable iff (reset)
        !active |=> state_ff == ST_IDLE
    ) else $error("timer ran while inactive");
    chk_cue_len: assert property (@(posedge core_clk) disable iff (reset)
        cue_mode && rate_div == 4'h1 |-> hi_len == 32'(CUE_HIGH_CYC)
    ) else $error("cue high length wrong");
    chk_rate_scale: assert property (@(posedge core_clk) disable iff (reset)
        !cue_mode && rate_div == 4'h2 |-> lo_len == 32'(2 * ROW_LOW_CYC)
    ) else $error("interval not scaled");
endmodule : rbp_row_pulse
`default_nettype wire

/* File: verification/rbp_spi_master.sv */
// Purpose: Serial master model driving the select, clock and input lines
// Assumes: 48 ns serial clock, idle low between frames
// Notes: Data line is inverted once the frame is over
`default_nettype none
module rbp_spi_master (
    output var logic sclk,
    output var logic ss_n,
    output var logic mosi
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic send(input logic [7:0] d, input int n);
        ss_n = 1'b0;
        for (int i = 7; i > 7 - n; i--)
        begin
            mosi = d[i];
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        #24 ss_n = 1'b1;
        mosi = ~mosi;
    endtask : send
endmodule : rbp_spi_master
`default_nettype wire

/* File: verification/rbp_row_pulse_bench.sv */
// Purpose: Bench for row pulse timing and serial pins
// Assumes: Interval counts shrunk through parameters
// Notes: Run lengths measured on the pulled-up pin
`default_nettype none
module rbp_row_pulse_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HI = 7, LO = 3, CHI = 5, CLO = 2;
    logic core_clk = 1'b0, reset = 1'b1, active = 1'b0, recording = 1'b0;
    logic cue_mode = 1'b0, miso_bit = 1'b1, rbp_o, rbp_oe, row_end, sclk, ss_n, mosi;
    logic miso_o, miso_oe, rx_valid;
    logic [3:0] rate_div = 4'h1;
    logic [7:0] rx_byte;
    int n_fail = 0, compares = 0, cyc = 0, f_play;
    wire row_pin = rbp_oe ? rbp_o : 1'b1;
    wire miso_pin = miso_oe ? miso_o : 1'bz;
    always #5 core_clk = ~core_clk;
    rbp_spi_master m_u (.sclk(sclk), .ss_n(ss_n), .mosi(mosi));
    rbp_row_pulse #(.ROW_HIGH_CYC(HI), .ROW_LOW_CYC(LO), .CUE_HIGH_CYC(CHI),
        .CUE_LOW_CYC(CLO)) dut_u (.core_clk(core_clk), .reset(reset), .active(active),
        .recording(recording), .cue_mode(cue_mode), .rate_div(rate_div),
        .row_boundary_pulse_o(rbp_o), .row_boundary_pulse_oe(rbp_oe), .row_end(row_end),
        .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso_bit(miso_bit), .miso_o(miso_o),
        .miso_oe(miso_oe), .rx_byte(rx_byte), .rx_valid(rx_valid));
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s exp %0h got %0h", w, e, g);
        end
    endtask : chk
    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (row_pin === lvl && n < 400)
        begin
            chk("row_end", !lvl, row_end);
            tick(1);
            n++;
        end
    endtask : run_len
    // Fresh reset each time so the record preload is seen again
    task automatic session(input logic rec, cue, input logic [3:0] div, output int f, l, h);
        reset = 1'b1;
        active = 1'b0;
        recording = rec;
        cue_mode = cue;
        rate_div = div;
        tick(2);
        reset = 1'b0;
        tick(2);
        active = 1'b1;
        run_len(1'b1, f);
        run_len(1'b0, l);
        run_len(1'b1, h);
        active = 1'b0;
    endtask : session
    task automatic wait_rx(input logic [7:0] e);
        int n = 0;
        while (rx_valid !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        chk("rx_valid", 1, rx_valid);
        chk("rx_byte", e, rx_byte);
    endtask : wait_rx
    task automatic t_rows();
        int f, l, h;
        session(1'b0, 1'b0, 4'h1, f_play, l, h);
        chk("low", LO, l);
        chk("high", HI, h);
        chk("period", HI + LO, l + h);
        session(1'b0, 1'b1, 4'h1, f, l, h);
        chk("cue_low", CLO, l);
        chk("cue_high", CHI, h);
        session(1'b0, 1'b0, 4'h2, f, l, h);
        chk("half_low", 2 * LO, l);
        chk("half_high", 2 * HI, h);
        session(1'b1, 1'b0, 4'h1, f, l, h);
        chk("rec_first", f_play + LO, f);
        chk("rec_low", LO, l);
    endtask : t_rows
    task automatic t_serial();
        chk("miso_idle", 1'bz, miso_pin);
        fork
            m_u.send(8'h5a, 8);
            wait_rx(8'h5a);
            begin
                tick(12);
                chk("miso_oe", 1, miso_oe);
                chk("miso_val", 1, miso_pin);
            end
        join
        tick(1);
        m_u.send(8'hff, 4);
        tick(1);
        miso_bit = 1'b0;
        fork
            m_u.send(8'h3c, 8);
            wait_rx(8'h3c);
            begin
                tick(12);
                chk("miso_low", 1'b0, miso_pin);
            end
        join
        tick(8);
        chk("miso_off", 1'bz, miso_pin);
    endtask : t_serial
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            stop_test();
        end
    end
    initial
    begin
        tick(4);
        reset = 1'b0;
        t_rows();
        t_serial();
        stop_test();
    end
endmodule : rbp_row_pulse_bench
`default_nettype wire
